// File: hw/pcar_pkg.sv
package pcar_pkg;

   // Host I/O addresses of the two ports.
   localparam logic [15:0] PCAR_ADDR_PTR = 16'h0CF8;
   localparam logic [15:0] PCAR_ADDR_WIN = 16'h0CFC;

   // Pointer register layout and reset value.
   localparam int PCAR_EN_BIT = 31;
   localparam int PCAR_BUS_HI = 23;
   localparam int PCAR_BUS_LO = 16;
   localparam int PCAR_DEV_HI = 15;
   localparam int PCAR_DEV_LO = 11;
   localparam int PCAR_FN_HI = 10;
   localparam int PCAR_FN_LO = 8;
   localparam int PCAR_REG_HI = 7;
   localparam int PCAR_REG_LO = 2;
   localparam logic [31:0] PCAR_PTR_RESET = 32'h0000_0000;
   localparam logic [31:0] PCAR_PTR_WMASK = 32'h80FF_FFFC;

   // Access sizes, decode constants and answers.
   localparam logic [3:0] PCAR_BE_DWORD = 4'hF;
   localparam logic [7:0] PCAR_BUS_ZERO = 8'h00;
   localparam logic [4:0] PCAR_DEV_FIRST_EXT = 5'h02;
   localparam logic [2:0] PCAR_FN_ZERO = 3'h0;
   localparam int PCAR_IDSEL_BASE = 16;
   localparam int PCAR_IDSEL_COUNT = 16;
   localparam logic [1:0] PCAR_T0_LOW = 2'h0;
   localparam logic [1:0] PCAR_T1_LOW = 2'h1;
   localparam logic [31:0] PCAR_IGNORED_RDATA = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {PCAR_CYC_IO, PCAR_CYC_CFG0, PCAR_CYC_CFG1} pcar_cyc_t;

   // Host I/O request.
   typedef struct packed {
      logic write;
      logic [15:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pcar_io_req_t;

   // Cycle forwarded to the hub interface or the graphics port.
   typedef struct packed {
      pcar_cyc_t cyc;
      logic write;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } pcar_fwd_t;

   // Access to an internal bridge function.
   typedef struct packed {
      logic write;
      logic dev;
      logic [5:0] reg_num;
      logic [3:0] be;
      logic [31:0] wdata;
   } pcar_int_t;

endpackage

// File: hw/pcar_router.sv
`timescale 1ns/1ps
// What this block does
// - Pointer claimed only on dword access; else forwarded.
// - Pointer bit 31 enables configuration accesses.
// - Pointer bits 30:24 read zero, not writable.
// - Bus zero, device two or more: hub.
// - Bus zero, device 0 or 1: internal.
// - Bus equals secondary: graphics Type 0.
// - Bus above secondary, within subordinate: graphics Type 1.
// - Bus outside bridge range: hub Type 1.
// - Graphics Type 0 decodes device into IDSEL line.
// - Device above 15: no IDSEL, record abort.
// - Device number on address bits 15:11, except graphics Type 0, where they are zero.
// - Function number on address bits 10:8.
// - Internal access with nonzero function is ignored.
// - Register number on address bits 7:2.
// - Window access while enabled becomes configuration access.
// - Disabled internal device forwarded to hub Type 0.
module pcar_router
   import pcar_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset_n,
   // Host I/O request and answer.
   input wire logic io_req_valid,
   output logic io_req_ready,
   input wire pcar_io_req_t io_req,
   output logic io_rsp_valid,
   output logic [31:0] io_rsp_rdata,
   // Bridge settings held by internal device 1 and device enables.
   input wire logic [7:0] secondary_bus,
   input wire logic [7:0] subordinate_bus,
   input wire logic [1:0] internal_dev_enable,
   // Internal bridge functions.
   output logic int_req_valid,
   output pcar_int_t int_req,
   input wire logic int_done,
   input wire logic [31:0] int_rdata,
   // Hub interface.
   output logic hub_req_valid,
   output pcar_fwd_t hub_req,
   input wire logic hub_done,
   input wire logic [31:0] hub_rdata,
   // Graphics port.
   output logic gfx_req_valid,
   output pcar_fwd_t gfx_req,
   input wire logic gfx_done,
   input wire logic [31:0] gfx_rdata,
   output logic gfx_master_abort
);

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_INT, ST_WAIT_HUB, ST_WAIT_GFX} pcar_state_t;

   pcar_state_t state_ff, nxt_state;
   logic [31:0] ptr_ff, nxt_ptr;
   logic rsp_valid_ff, nxt_rsp_valid;
   logic [31:0] rsp_rdata_ff, nxt_rsp_rdata;
   logic int_valid_ff, nxt_int_valid;
   pcar_int_t int_req_ff, nxt_int_req;
   logic hub_valid_ff, nxt_hub_valid;
   pcar_fwd_t hub_req_ff, nxt_hub_req;
   logic gfx_valid_ff, nxt_gfx_valid;
   pcar_fwd_t gfx_req_ff, nxt_gfx_req;
   logic abort_ff, nxt_abort;

   logic cfg_en;
   logic [7:0] bus_num;
   logic [4:0] dev_num;
   logic [2:0] fn_num;
   logic [5:0] reg_num;
   logic [15:0] idsel;
   logic accept;
   logic is_ptr;
   logic is_win;
   logic dword;
   logic [23:0] lower_fields;

   ////////////////////////////////////////////////////////////////////////////
   // Field decode of the pointer register.

   assign cfg_en = ptr_ff[PCAR_EN_BIT];
   assign bus_num = ptr_ff[PCAR_BUS_HI:PCAR_BUS_LO];
   assign dev_num = ptr_ff[PCAR_DEV_HI:PCAR_DEV_LO];
   assign fn_num = ptr_ff[PCAR_FN_HI:PCAR_FN_LO];
   assign reg_num = ptr_ff[PCAR_REG_HI:PCAR_REG_LO];
   assign lower_fields = {bus_num, dev_num, fn_num, reg_num, 2'h0};
   assign io_req_ready = (state_ff == ST_IDLE);
   assign accept = io_req_valid && io_req_ready;
   assign is_ptr = (io_req.addr == PCAR_ADDR_PTR);
   assign is_win = (io_req.addr == PCAR_ADDR_WIN);
   assign dword = (io_req.be == PCAR_BE_DWORD);

   // One IDSEL line per device 0 to 15; device bit 4 set leaves all low.
   for (genvar i = 0; i < PCAR_IDSEL_COUNT; i++) begin : g_idsel
      assign idsel[i] = !dev_num[4] && (dev_num[3:0] == 4'(i));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Request routing and completion.

   always_comb begin
      nxt_state = state_ff;
      nxt_ptr = ptr_ff;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_rdata = rsp_rdata_ff;
      nxt_int_valid = int_valid_ff;
      nxt_int_req = int_req_ff;
      nxt_hub_valid = hub_valid_ff;
      nxt_hub_req = hub_req_ff;
      nxt_gfx_valid = gfx_valid_ff;
      nxt_gfx_req = gfx_req_ff;
      nxt_abort = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (accept) begin
               nxt_hub_req = '{PCAR_CYC_IO, io_req.write, {16'h0000, io_req.addr}, io_req.be, io_req.wdata};
               nxt_gfx_req = '{PCAR_CYC_CFG0, io_req.write, 32'h0000_0000, io_req.be, io_req.wdata};
               nxt_int_req = '{io_req.write, dev_num[0], reg_num, io_req.be, io_req.wdata};
               if (is_ptr && dword) begin
                  // Reserved positions are masked so they never store a one.
                  if (io_req.write) begin
                     nxt_ptr = io_req.wdata & PCAR_PTR_WMASK;
                  end
                  nxt_rsp_rdata = ptr_ff;
                  nxt_rsp_valid = 1'b1;
               end else if (is_win && cfg_en) begin
                  if (bus_num == PCAR_BUS_ZERO) begin
                     if (dev_num >= PCAR_DEV_FIRST_EXT || !internal_dev_enable[dev_num[0]]) begin
                        nxt_hub_req.cyc = PCAR_CYC_CFG0;
                        nxt_hub_req.addr = {8'h00, lower_fields};
                        nxt_hub_valid = 1'b1;
                        nxt_state = ST_WAIT_HUB;
                     end else if (fn_num != PCAR_FN_ZERO) begin
                        nxt_rsp_rdata = PCAR_IGNORED_RDATA;
                        nxt_rsp_valid = 1'b1;
                     end else begin
                        nxt_int_valid = 1'b1;
                        nxt_state = ST_WAIT_INT;
                     end
                  end else if (bus_num == secondary_bus) begin
                     nxt_gfx_req.addr = {idsel, 5'h00, fn_num, reg_num, PCAR_T0_LOW};
                     nxt_gfx_valid = 1'b1;
                     nxt_state = ST_WAIT_GFX;
                  end else if (bus_num > secondary_bus && bus_num <= subordinate_bus) begin
                     nxt_gfx_req.cyc = PCAR_CYC_CFG1;
                     nxt_gfx_req.addr = {8'h00, bus_num, dev_num, fn_num, reg_num, PCAR_T1_LOW};
                     nxt_gfx_valid = 1'b1;
                     nxt_state = ST_WAIT_GFX;
                  end else begin
                     nxt_hub_req.cyc = PCAR_CYC_CFG1;
                     nxt_hub_req.addr = {8'h00, bus_num, dev_num, fn_num, reg_num, PCAR_T1_LOW};
                     nxt_hub_valid = 1'b1;
                     nxt_state = ST_WAIT_HUB;
                  end
               end else begin
                  // Partial pointer access, disabled window and other ports go out as I/O.
                  nxt_hub_valid = 1'b1;
                  nxt_state = ST_WAIT_HUB;
               end
            end
         end
         ST_WAIT_INT: begin
            if (int_done) begin
               nxt_int_valid = 1'b0;
               nxt_rsp_rdata = int_rdata;
               nxt_rsp_valid = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_WAIT_HUB: begin
            if (hub_done) begin
               nxt_hub_valid = 1'b0;
               nxt_rsp_rdata = hub_rdata;
               nxt_rsp_valid = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
         ST_WAIT_GFX: begin
            if (gfx_done) begin
               nxt_gfx_valid = 1'b0;
               nxt_rsp_rdata = gfx_rdata;
               nxt_rsp_valid = 1'b1;
               nxt_abort = (gfx_req_ff.cyc == PCAR_CYC_CFG0) && (gfx_req_ff.addr[31:16] == 16'h0000);
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
         ptr_ff <= PCAR_PTR_RESET;
         rsp_valid_ff <= 1'b0;
         rsp_rdata_ff <= 32'h0000_0000;
         int_valid_ff <= 1'b0;
         int_req_ff <= '0;
         hub_valid_ff <= 1'b0;
         hub_req_ff <= '0;
         gfx_valid_ff <= 1'b0;
         gfx_req_ff <= '0;
         abort_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ptr_ff <= nxt_ptr;
         rsp_valid_ff <= nxt_rsp_valid;
         rsp_rdata_ff <= nxt_rsp_rdata;
         int_valid_ff <= nxt_int_valid;
         int_req_ff <= nxt_int_req;
         hub_valid_ff <= nxt_hub_valid;
         hub_req_ff <= nxt_hub_req;
         gfx_valid_ff <= nxt_gfx_valid;
         gfx_req_ff <= nxt_gfx_req;
         abort_ff <= nxt_abort;
      end
   end

   assign io_rsp_valid = rsp_valid_ff;
   assign io_rsp_rdata = rsp_rdata_ff;
   assign int_req_valid = int_valid_ff;
   assign int_req = int_req_ff;
   assign hub_req_valid = hub_valid_ff;
   assign hub_req = hub_req_ff;
   assign gfx_req_valid = gfx_valid_ff;
   assign gfx_req = gfx_req_ff;
   assign gfx_master_abort = abort_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   logic win_cfg;
   assign win_cfg = accept && is_win && cfg_en;

   a_ptr_reserved_zero: assert property (
      ptr_ff[30:24] == 7'h00 && ptr_ff[1:0] == 2'h0)
      else $error("pointer reserved bits not zero");
   a_ptr_partial_io: assert property (
      accept && is_ptr && !dword |=> hub_req_valid && hub_req.cyc == PCAR_CYC_IO && $stable(ptr_ff))
      else $error("partial pointer access not forwarded as I/O");
   a_ptr_readback: assert property (
      accept && is_ptr && dword && !io_req.write |=> io_rsp_valid && io_rsp_rdata == ptr_ff)
      else $error("pointer read does not return stored value");
   a_win_disabled_io: assert property (
      accept && is_win && !cfg_en |=> hub_req_valid && hub_req.cyc == PCAR_CYC_IO && !gfx_req_valid)
      else $error("disabled window access not forwarded as I/O");
   a_hub_type0_fields: assert property (
      win_cfg && bus_num == PCAR_BUS_ZERO && dev_num >= PCAR_DEV_FIRST_EXT
      |=> hub_req_valid && hub_req.cyc == PCAR_CYC_CFG0 && hub_req.addr[23:0] == lower_fields)
      else $error("bus zero external device not sent to hub as Type 0");
   a_internal_route: assert property (
      win_cfg && bus_num == PCAR_BUS_ZERO && dev_num < PCAR_DEV_FIRST_EXT && fn_num == PCAR_FN_ZERO
      && internal_dev_enable[dev_num[0]] |=> int_req_valid && !hub_req_valid && int_req.dev == dev_num[0])
      else $error("internal device access not served internally");
   a_internal_ignore: assert property (
      win_cfg && bus_num == PCAR_BUS_ZERO && dev_num < PCAR_DEV_FIRST_EXT && fn_num != PCAR_FN_ZERO
      && internal_dev_enable[dev_num[0]] |=> io_rsp_valid && !int_req_valid && !hub_req_valid)
      else $error("nonzero function reached internal device");
   a_disabled_forward: assert property (
      win_cfg && bus_num == PCAR_BUS_ZERO && dev_num < PCAR_DEV_FIRST_EXT && !internal_dev_enable[dev_num[0]]
      |=> hub_req_valid && hub_req.cyc == PCAR_CYC_CFG0)
      else $error("disabled internal device not forwarded");
   a_gfx_type0_idsel: assert property (
      win_cfg && bus_num != PCAR_BUS_ZERO && bus_num == secondary_bus && !dev_num[4]
      |=> gfx_req.cyc == PCAR_CYC_CFG0 && gfx_req.addr[31:16] == (16'h0001 << dev_num[3:0]))
      else $error("wrong IDSEL line on graphics Type 0");
   a_gfx_abort_flag: assert property (
      gfx_req_valid && gfx_done && gfx_req.cyc == PCAR_CYC_CFG0 && gfx_req.addr[31:16] == 16'h0000
      |=> gfx_master_abort ##1 !gfx_master_abort)
      else $error("master abort not recorded for missing IDSEL");
   a_gfx_type1_fields: assert property (
      win_cfg && bus_num != PCAR_BUS_ZERO && bus_num > secondary_bus && bus_num <= subordinate_bus
      |=> gfx_req_valid && gfx_req.cyc == PCAR_CYC_CFG1 && gfx_req.addr[23:2] == lower_fields[23:2])
      else $error("graphics Type 1 cycle malformed");
   a_hub_type1_route: assert property (
      win_cfg && bus_num != PCAR_BUS_ZERO && (bus_num < secondary_bus || bus_num > subordinate_bus)
      |=> hub_req_valid && hub_req.cyc == PCAR_CYC_CFG1 && hub_req.addr[1:0] == PCAR_T1_LOW)
      else $error("out of range bus not sent to hub as Type 1");
   a_done_answer: assert property (
      hub_req_valid && hub_done |=> io_rsp_valid && !hub_req_valid && io_req_ready)
      else $error("hub completion not answered next cycle");
   a_int_answer: assert property (
      int_req_valid && int_done |=> io_rsp_valid && io_rsp_rdata == $past(int_rdata) && !int_req_valid)
      else $error("internal completion not answered next cycle");
   a_gfx_low_fields: assert property (
      win_cfg && bus_num != PCAR_BUS_ZERO && bus_num == secondary_bus
      |=> gfx_req.addr[10:2] == {fn_num, reg_num} && gfx_req.addr[1:0] == PCAR_T0_LOW)
      else $error("graphics Type 0 function or register field wrong");

   c_internal_access: cover property (accept ##1 int_req_valid ##[1:20] io_rsp_valid);
   c_gfx_type1: cover property (gfx_req_valid && gfx_req.cyc == PCAR_CYC_CFG1 && gfx_done);
   c_gfx_abort: cover property (gfx_master_abort);
   c_hub_type0: cover property (hub_req_valid && hub_req.cyc == PCAR_CYC_CFG0 && hub_done);
   c_ptr_write_then_win: cover property (accept && is_ptr && io_req.write ##[1:4] win_cfg);

endmodule

// File: sim/pcar_target_model.sv
`timescale 1ns/1ps
module pcar_target_model
   import pcar_pkg::*;
#(
   parameter logic [31:0] DATA = 32'h0000_0000
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset_n,
   // Request from the router and the answer to it.
   input wire logic req_valid,
   input wire logic [3:0] lat,
   output logic done,
   output logic [31:0] rdata
);
   logic [3:0] cnt_ff, nxt_cnt;
   logic done_ff, nxt_done;

   // A done pulse only answers a request that is still held, after lat waiting cycles.
   always_comb begin
      nxt_done = req_valid && !done_ff && (cnt_ff == lat);
      nxt_cnt = (req_valid && !done_ff && !nxt_done) ? cnt_ff + 4'h1 : 4'h0;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 4'h0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign done = done_ff;
   // Outside the pulse the data lines carry the inverse, so a stale sample never matches.
   assign rdata = done_ff ? DATA : ~DATA;
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pcar_pkg::*;
   localparam logic [31:0] INTD = 32'h1111_0000;
   localparam logic [31:0] HUBD = 32'h2222_0000;
   localparam logic [31:0] GFXD = 32'h3333_0000;
   localparam logic [31:0] WD = 32'hA5C3_5A3C;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic io_req_valid = 1'b0;
   pcar_io_req_t io_req = '0;
   logic [7:0] secondary_bus = 8'h05;
   logic [7:0] subordinate_bus = 8'h07;
   logic [1:0] internal_dev_enable = 2'h3;
   logic io_req_ready, io_rsp_valid, int_req_valid, int_done, hub_req_valid, hub_done;
   logic gfx_req_valid, gfx_done, gfx_master_abort, got_abort;
   logic [31:0] io_rsp_rdata, int_rdata, hub_rdata, gfx_rdata, got_rd, got_addr, got_wd;
   pcar_int_t int_req;
   pcar_fwd_t hub_req, gfx_req;
   pcar_cyc_t got_cyc;
   logic [1:0] got_tgt;
   logic [4:0] got_ctl;
   int got_k;
   int lat_k[4] = '{0, 3, 7, 2};
   int n_errors = 0;
   int tests_run = 0;

   always #2 ref_clk = ~ref_clk;

   pcar_router dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .io_req_valid(io_req_valid),
      .io_req_ready(io_req_ready), .io_req(io_req), .io_rsp_valid(io_rsp_valid), .io_rsp_rdata(io_rsp_rdata),
      .secondary_bus(secondary_bus), .subordinate_bus(subordinate_bus), .internal_dev_enable(internal_dev_enable),
      .int_req_valid(int_req_valid), .int_req(int_req), .int_done(int_done), .int_rdata(int_rdata),
      .hub_req_valid(hub_req_valid), .hub_req(hub_req), .hub_done(hub_done), .hub_rdata(hub_rdata),
      .gfx_req_valid(gfx_req_valid), .gfx_req(gfx_req), .gfx_done(gfx_done), .gfx_rdata(gfx_rdata),
      .gfx_master_abort(gfx_master_abort));
   pcar_target_model #(.DATA(INTD)) int_m (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(int_req_valid),
      .lat(4'h1), .done(int_done), .rdata(int_rdata));
   pcar_target_model #(.DATA(HUBD)) hub_m (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(hub_req_valid),
      .lat(4'h5), .done(hub_done), .rdata(hub_rdata));
   pcar_target_model #(.DATA(GFXD)) gfx_m (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(gfx_req_valid),
      .lat(4'h0), .done(gfx_done), .rdata(gfx_rdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d.", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [31:0] p(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f,
                                     input logic [5:0] r);
      return {1'b1, 7'h00, b, d, f, r, 2'h0};
   endfunction

   function automatic logic [31:0] h(input logic [31:0] ptr, input logic t1);
      return (ptr & 32'h00FF_FFFC) | {31'h0, t1};
   endfunction

   // One host access; records which target saw it, what it carried and the answer delay.
   task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
      got_tgt = 2'h0;
      got_cyc = PCAR_CYC_IO;
      @(negedge ref_clk);
      io_req = '{wr, a, be, wd};
      io_req_valid = 1'b1;
      while (io_req_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      io_req_valid = 1'b0;
      for (got_k = 0; got_k < 20 && io_rsp_valid !== 1'b1; got_k++) begin
         if (int_req_valid === 1'b1) begin
            got_tgt = 2'h1;
            got_addr = {25'h0, int_req.dev, int_req.reg_num};
            {got_ctl, got_wd} = {int_req.write, int_req.be, int_req.wdata};
         end
         if (hub_req_valid === 1'b1) begin
            got_tgt = 2'h2;
            {got_addr, got_cyc, got_wd} = {hub_req.addr, hub_req.cyc, hub_req.wdata};
            got_ctl = {hub_req.write, hub_req.be};
         end
         if (gfx_req_valid === 1'b1) begin
            got_tgt = 2'h3;
            {got_addr, got_cyc, got_wd} = {gfx_req.addr, gfx_req.cyc, gfx_req.wdata};
            got_ctl = {gfx_req.write, gfx_req.be};
         end
         chk("ready while busy", 32'h0, {31'h0, io_req_ready});
         @(negedge ref_clk);
      end
      got_rd = io_rsp_rdata;
      got_abort = gfx_master_abort;
   endtask

   task automatic cfg(input logic [31:0] ptr, input logic wr, input logic [1:0] tgt, input pcar_cyc_t cyc,
                      input logic [31:0] addr, input logic [31:0] rd);
      io(1'b1, PCAR_ADDR_PTR, PCAR_BE_DWORD, ptr);
      io(wr, PCAR_ADDR_WIN, PCAR_BE_DWORD, WD);
      chk("target", {30'h0, tgt}, {30'h0, got_tgt});
      chk("latency", lat_k[tgt], got_k);
      if (tgt > 2'h1) chk("cycle kind", {30'h0, cyc}, {30'h0, got_cyc});
      if (tgt != 2'h0) chk("address", addr, got_addr);
      if (tgt != 2'h0) chk("write and enables", {27'h0, wr, PCAR_BE_DWORD}, {27'h0, got_ctl});
      if (!wr) chk("read data", rd, got_rd);
      else if (tgt != 2'h0) chk("write data", WD, got_wd);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_pointer();
      chk("ready after reset", 32'h1, {31'h0, io_req_ready});
      io(1'b0, PCAR_ADDR_PTR, PCAR_BE_DWORD, 32'h0);
      chk("pointer reset", 32'h0000_0000, got_rd);
      chk("local latency", 32'h0, got_k);
      io(1'b1, PCAR_ADDR_PTR, PCAR_BE_DWORD, 32'hFFFF_FFFF);
      io(1'b0, PCAR_ADDR_PTR, PCAR_BE_DWORD, 32'h0);
      chk("pointer readback", 32'h80FF_FFFC, got_rd);
      io(1'b1, PCAR_ADDR_PTR, 4'h3, 32'h0);
      chk("partial target", 32'h2, {30'h0, got_tgt});
      chk("partial address", 32'h0000_0CF8, got_addr);
      chk("partial kind", {30'h0, PCAR_CYC_IO}, {30'h0, got_cyc});
      chk("partial enables", 32'h0000_0013, {27'h0, got_ctl});
      io(1'b0, PCAR_ADDR_PTR, PCAR_BE_DWORD, 32'h0);
      chk("pointer kept", 32'h80FF_FFFC, got_rd);
   endtask

   task automatic t_routes();
      cfg(32'h0000_1804, 1'b0, 2'h2, PCAR_CYC_IO, 32'h0000_0CFC, HUBD);
      cfg(p(8'h00, 5'h03, 3'h2, 6'h05), 1'b0, 2'h2, PCAR_CYC_CFG0, h(p(8'h00, 5'h03, 3'h2, 6'h05), 1'b0), HUBD);
      cfg(p(8'h00, 5'h00, 3'h0, 6'h09), 1'b1, 2'h1, PCAR_CYC_IO, 32'h0000_0009, 32'h0);
      cfg(p(8'h00, 5'h01, 3'h0, 6'h03), 1'b0, 2'h1, PCAR_CYC_IO, 32'h0000_0043, INTD);
      cfg(p(8'h00, 5'h01, 3'h3, 6'h03), 1'b0, 2'h0, PCAR_CYC_IO, 32'h0, PCAR_IGNORED_RDATA);
      cfg(p(8'h00, 5'h00, 3'h7, 6'h03), 1'b1, 2'h0, PCAR_CYC_IO, 32'h0, 32'h0);
      cfg(p(8'h08, 5'h1F, 3'h7, 6'h3F), 1'b1, 2'h2, PCAR_CYC_CFG1, h(p(8'h08, 5'h1F, 3'h7, 6'h3F), 1'b1), 32'h0);
      cfg(p(8'h03, 5'h04, 3'h1, 6'h02), 1'b0, 2'h2, PCAR_CYC_CFG1, h(p(8'h03, 5'h04, 3'h1, 6'h02), 1'b1), HUBD);
      @(negedge ref_clk);
      internal_dev_enable = 2'h1;
      cfg(p(8'h00, 5'h01, 3'h0, 6'h02), 1'b0, 2'h2, PCAR_CYC_CFG0, h(p(8'h00, 5'h01, 3'h0, 6'h02), 1'b0), HUBD);
      internal_dev_enable = 2'h3;
   endtask

   task automatic t_gfx();
      for (int d = 0; d < 16; d++) begin
         cfg(p(8'h05, 5'(d), 3'h1, 6'h06), 1'b0, 2'h3, PCAR_CYC_CFG0, {16'h0001 << d, 5'h00, 3'h1, 6'h06, 2'h0}, GFXD);
         chk("no abort", 32'h0, {31'h0, got_abort});
      end
      cfg(p(8'h05, 5'h11, 3'h0, 6'h01), 1'b0, 2'h3, PCAR_CYC_CFG0, 32'h0000_0004, GFXD);
      chk("abort", 32'h1, {31'h0, got_abort});
      cfg(p(8'h07, 5'h02, 3'h5, 6'h04), 1'b1, 2'h3, PCAR_CYC_CFG1, h(p(8'h07, 5'h02, 3'h5, 6'h04), 1'b1), 32'h0);
      cfg(p(8'h06, 5'h1E, 3'h0, 6'h3C), 1'b0, 2'h3, PCAR_CYC_CFG1, h(p(8'h06, 5'h1E, 3'h0, 6'h3C), 1'b1), GFXD);
   endtask

   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      t_pointer();
      t_routes();
      t_gfx();
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      report_and_stop();
   end
endmodule
